// file: src/nv_write_guard.sv
`timescale 1ns/10ps
`default_nettype none

// Decides whether a table write may touch the nonvolatile copy.
module nv_write_guard #(
  parameter longint unsigned RATE_CYCLES = servo_cmd_pkg::NV_RATE_CYCLES,
  parameter int unsigned     LIMIT       = servo_cmd_pkg::NV_WRITE_LIMIT
) (
  input  wire logic        clk,
  input  wire logic        rstN,
  input  wire logic        wantNv,
  input  wire logic        commit,
  output logic             allowNv,
  output logic             exhausted,
  output logic [31:0]      nvCount
);
  import servo_cmd_pkg::*;

  logic [63:0] rateCnt_q;
  logic        recent_q;
  logic [31:0] nvCount_q;

  // ****************************************
  // One-hour window after each nonvolatile write
  // ****************************************
  // R8 rate window
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rateCnt_q <= 64'h0000_0000_0000_0000;
      recent_q  <= 1'b0;
    end else if (commit && allowNv) begin
      rateCnt_q <= 64'h0000_0000_0000_0000;
      recent_q  <= 1'b1;
    end else if (recent_q) begin
      if (rateCnt_q >= RATE_CYCLES - 64'd1) begin
        recent_q <= 1'b0;
      end
      rateCnt_q <= rateCnt_q + 64'd1;
    end
  end

  // ****************************************
  // Endurance count
  // ****************************************
  // R9 endurance budget
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      nvCount_q <= 32'h0000_0000;
    end else if (commit && allowNv) begin
      nvCount_q <= nvCount_q + 32'd1;
    end
  end

  // Saturating budget: once spent, every later write until the next reset is demoted to RAM only
  assign exhausted = (nvCount_q >= LIMIT);
  // R8 demote frequent
  assign allowNv   = wantNv && !recent_q && !exhausted;
  assign nvCount   = nvCount_q;

endmodule : nv_write_guard

`default_nettype wire

// file: src/servo_cmd_host.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1 - Position write: code C0, entry 01..FF
// R2 - Speed write: code C6, entry 01..FF
// R3 - Acceleration write: code C7, entry 01..FF
// R4 - Deceleration write: code C8, entry 01..FF
// R5 - Dwell write: code CA, entry 01..FF
// R6 - Auxiliary write: code CB, entry 01..FF
// R7 - Mode digit 0 nonvolatile+RAM, 1 RAM only
// R8 - Frequent changes within an hour use RAM
// R9 - Keep nonvolatile writes below one hundred thousand (guard allows NV_WRITE_LIMIT writes, and reset clears the count)
// R10 - Every station holds its group assignment
// R11 - Group write: code 9F, number 00
// R12 - Group read: code 1F, number 00
// R13 - Group read returns stored group setting
// R14 - Pulse position read: code 02, number 90
// R15 - Pulse position returned in motor pulses
// R16 - Pulse position wraps beyond 8192 revolutions
// R17 - Command position read: code 02, number 91
// R18 - Command position returned in command units
// R19 - Group data: code 0..6 plus reply flag
module servo_cmd_host #(
  parameter longint unsigned NV_RATE_CYC = servo_cmd_pkg::NV_RATE_CYCLES,
  parameter int unsigned     NV_LIMIT    = servo_cmd_pkg::NV_WRITE_LIMIT,
  parameter int unsigned     TIMEOUT_CYC = servo_cmd_pkg::REPLY_TIMEOUT
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // User request side
  input  wire logic                                  reqValid,
  output logic                                       reqReady,
  input  wire servo_cmd_pkg::op_t                    reqOp,
  input  wire logic [servo_cmd_pkg::DNO_W-1:0]       reqEntry,
  input  wire logic [servo_cmd_pkg::DATA_W-1:0]      reqValue,
  input  wire logic                                  reqRamOnly,
  input  wire logic [servo_cmd_pkg::GRP_CODE_W-1:0]  reqGroup,
  input  wire logic                                  reqGroupReply,
  output logic                                       respValid,
  output logic [servo_cmd_pkg::DATA_W-1:0]           respData,
  output logic                                       respErr,
  output logic                                       respDemoted,
  output logic [31:0]                                nvWriteCount,
  output logic                                       nvExhausted,
  // Link toward the station
  output logic                                       linkReq,
  output logic [servo_cmd_pkg::CMD_W-1:0]            linkCmd,
  output logic [servo_cmd_pkg::DNO_W-1:0]            linkDataNo,
  output logic [servo_cmd_pkg::DATA_W-1:0]           linkData,
  output logic [servo_cmd_pkg::MODE_W-1:0]           linkMode,
  input  wire logic                                  linkAck,
  input  wire logic [servo_cmd_pkg::DATA_W-1:0]      linkRdData,
  input  wire logic                                  linkErr
);
  import servo_cmd_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic isTableWrite(input op_t op);
    case (op)
      OP_TBL_POS, OP_TBL_SPD, OP_TBL_ACC,
      OP_TBL_DEC, OP_TBL_DWELL, OP_TBL_AUX: isTableWrite = 1'b1;
      default:                              isTableWrite = 1'b0;
    endcase
  endfunction : isTableWrite

  function automatic logic [CMD_W-1:0] opToCmd(input op_t op);
    case (op)
      // R1 position code
      OP_TBL_POS:   opToCmd = CMD_TBL_POS;
      // R2 speed code
      OP_TBL_SPD:   opToCmd = CMD_TBL_SPD;
      // R3 acceleration code
      OP_TBL_ACC:   opToCmd = CMD_TBL_ACC;
      // R4 deceleration code
      OP_TBL_DEC:   opToCmd = CMD_TBL_DEC;
      // R5 dwell code
      OP_TBL_DWELL: opToCmd = CMD_TBL_DWELL;
      // R6 auxiliary code
      OP_TBL_AUX:   opToCmd = CMD_TBL_AUX;
      // R11 group write code
      OP_GRP_WR:    opToCmd = CMD_GRP_WR;
      // R12 group read code
      OP_GRP_RD:    opToCmd = CMD_GRP_RD;
      // R14 R17 monitor read code
      default:      opToCmd = CMD_MON_RD;
    endcase
  endfunction : opToCmd

  function automatic logic [DNO_W-1:0] opToDataNo(input op_t op, input logic [DNO_W-1:0] entry);
    case (op)
      OP_GRP_WR, OP_GRP_RD: opToDataNo = DNO_GROUP;
      // R14 pulse position number
      OP_ABS_PULSE:         opToDataNo = DNO_ABS_PULSE;
      // R17 command position number
      OP_ABS_CMD:           opToDataNo = DNO_ABS_CMD;
      default:              opToDataNo = entry;
    endcase
  endfunction : opToDataNo

  function automatic logic opKnown(input op_t op);
    opKnown = (op <= OP_ABS_CMD);
  endfunction : opKnown

  // ****************************************
  // Reset release
  // ****************************************
  logic rstSync1_q;
  logic rstSync2_q;
  logic rstN_i;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstN_i = rstSync2_q;

  // ****************************************
  // Request check and nonvolatile guard
  // ****************************************
  logic                 take;
  logic                 reqBad;
  logic                 wantNv;
  logic                 allowNv;
  logic                 guardCommit;
  logic                 exhausted;
  logic [31:0]          nvCount;
  logic [DATA_W-1:0]    grpWord;
  state_t               state_q;

  assign take = reqValid && reqReady;

  // R1 entry range
  assign reqBad = !opKnown(reqOp) ||
                  (isTableWrite(reqOp) && (reqEntry < DNO_TBL_FIRST || reqEntry > DNO_TBL_LAST)) ||
                  // R19 group code range
                  (reqOp == OP_GRP_WR && reqGroup > GRP_LAST);

  assign wantNv      = isTableWrite(reqOp) && !reqRamOnly;
  assign guardCommit = take && !reqBad && isTableWrite(reqOp);

  // R19 group data layout
  always_comb begin
    grpWord = '0;
    grpWord[GRP_CODE_LSB +: GRP_CODE_W] = reqGroup;
    grpWord[GRP_REPLY_BIT]              = reqGroupReply;
  end

  nv_write_guard #(
    .RATE_CYCLES (NV_RATE_CYC),
    .LIMIT       (NV_LIMIT)
  ) u_guard (
    .clk       (clk),
    .rstN      (rstN_i),
    .wantNv    (wantNv),
    .commit    (guardCommit),
    .allowNv   (allowNv),
    .exhausted (exhausted),
    .nvCount   (nvCount)
  );

  // ****************************************
  // Transfer sequencer
  // ****************************************
  logic [31:0] waitCnt_q;
  logic        timedOut;

  assign timedOut = (waitCnt_q >= TIMEOUT_CYC - 1);

  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= reqBad ? ST_DONE : ST_SEND;
          end
        end
        ST_SEND: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (linkAck || timedOut) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Bounded wait so a silent station cannot hang the host
  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      waitCnt_q <= 32'h0000_0000;
    end else if (state_q == ST_WAIT) begin
      waitCnt_q <= waitCnt_q + 32'd1;
    end else begin
      waitCnt_q <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Link fields, held for the whole transfer
  // ****************************************
  logic              linkReq_q;
  logic [CMD_W-1:0]  linkCmd_q;
  logic [DNO_W-1:0]  linkDataNo_q;
  logic [DATA_W-1:0] linkData_q;
  logic [MODE_W-1:0] linkMode_q;
  logic              demoted_q;

  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      linkCmd_q    <= 8'h00;
      linkDataNo_q <= 8'h00;
      linkData_q   <= 32'h0000_0000;
      linkMode_q   <= MODE_NV_RAM;
      demoted_q    <= 1'b0;
    end else if (take && !reqBad) begin
      linkCmd_q    <= opToCmd(reqOp);
      linkDataNo_q <= opToDataNo(reqOp, reqEntry);
      // R10 R11 group assignment written
      linkData_q   <= (reqOp == OP_GRP_WR) ? grpWord :
                      isTableWrite(reqOp) ? reqValue : 32'h0000_0000;
      // R7 write mode digit
      linkMode_q   <= allowNv ? MODE_NV_RAM : MODE_RAM_ONLY;
      // R9 demoted report
      demoted_q    <= wantNv && !allowNv;
    end
  end

  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      linkReq_q <= 1'b0;
    end else if (state_q == ST_SEND) begin
      linkReq_q <= 1'b1;
    end else if (state_q == ST_WAIT && (linkAck || timedOut)) begin
      linkReq_q <= 1'b0;
    end
  end

  // ****************************************
  // Answer to the user
  // ****************************************
  logic              reqReady_q;
  logic              respValid_q;
  logic [DATA_W-1:0] respData_q;
  logic              respErr_q;
  logic              respDemoted_q;
  logic              badHeld_q;
  logic [31:0]       nvCount_q;
  logic              exhausted_q;

  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      reqReady_q <= 1'b0;
    end else begin
      reqReady_q <= (state_q == ST_IDLE) && !take;
    end
  end

  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      badHeld_q <= 1'b0;
    end else if (take) begin
      badHeld_q <= reqBad;
    end
  end

  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      respValid_q   <= 1'b0;
      respData_q    <= 32'h0000_0000;
      respErr_q     <= 1'b0;
      respDemoted_q <= 1'b0;
    end else begin
      respValid_q <= 1'b0;
      if (state_q == ST_DONE && badHeld_q) begin
        respValid_q   <= 1'b1;
        respData_q    <= 32'h0000_0000;
        respErr_q     <= 1'b1;
        respDemoted_q <= 1'b0;
      end else if (state_q == ST_WAIT && (linkAck || timedOut)) begin
        respValid_q   <= 1'b1;
        // R13 R15 R18 reply passthrough
        // R16 raw wrapped count kept
        respData_q    <= linkAck ? linkRdData : 32'h0000_0000;
        respErr_q     <= !linkAck || linkErr;
        respDemoted_q <= demoted_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN_i) begin
    if (!rstN_i) begin
      nvCount_q   <= 32'h0000_0000;
      exhausted_q <= 1'b0;
    end else begin
      nvCount_q   <= nvCount;
      exhausted_q <= exhausted;
    end
  end

  assign reqReady     = reqReady_q;
  assign respValid    = respValid_q;
  assign respData     = respData_q;
  assign respErr      = respErr_q;
  assign respDemoted  = respDemoted_q;
  assign nvWriteCount = nvCount_q;
  assign nvExhausted  = exhausted_q;
  assign linkReq      = linkReq_q;
  assign linkCmd      = linkCmd_q;
  assign linkDataNo   = linkDataNo_q;
  assign linkData     = linkData_q;
  assign linkMode     = linkMode_q;

endmodule : servo_cmd_host

`default_nettype wire

// file: src/servo_cmd_pkg.sv
package servo_cmd_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam longint unsigned CLK_HZ         = 64'd200_000_000;
  localparam longint unsigned NV_RATE_SEC    = 64'd3600;
  localparam longint unsigned NV_RATE_CYCLES = NV_RATE_SEC * CLK_HZ;
  localparam int unsigned     NV_WRITE_LIMIT = 100_000;
  localparam int unsigned     REPLY_TIMEOUT  = 1024;

  // ****************************************
  // Link field widths
  // ****************************************
  localparam int CMD_W  = 8;
  localparam int DNO_W  = 8;
  localparam int DATA_W = 32;
  localparam int MODE_W = 4;

  // ****************************************
  // Command codes and data numbers
  // ****************************************
  localparam logic [CMD_W-1:0] CMD_TBL_POS   = 8'hC0;
  localparam logic [CMD_W-1:0] CMD_TBL_SPD   = 8'hC6;
  localparam logic [CMD_W-1:0] CMD_TBL_ACC   = 8'hC7;
  localparam logic [CMD_W-1:0] CMD_TBL_DEC   = 8'hC8;
  localparam logic [CMD_W-1:0] CMD_TBL_DWELL = 8'hCA;
  localparam logic [CMD_W-1:0] CMD_TBL_AUX   = 8'hCB;
  localparam logic [CMD_W-1:0] CMD_GRP_WR    = 8'h9F;
  localparam logic [CMD_W-1:0] CMD_GRP_RD    = 8'h1F;
  localparam logic [CMD_W-1:0] CMD_MON_RD    = 8'h02;

  localparam logic [DNO_W-1:0] DNO_TBL_FIRST = 8'h01;
  localparam logic [DNO_W-1:0] DNO_TBL_LAST  = 8'hFF;
  localparam logic [DNO_W-1:0] DNO_GROUP     = 8'h00;
  localparam logic [DNO_W-1:0] DNO_ABS_PULSE = 8'h90;
  localparam logic [DNO_W-1:0] DNO_ABS_CMD   = 8'h91;

  // ****************************************
  // Write mode digit and group data layout
  // ****************************************
  localparam logic [MODE_W-1:0] MODE_NV_RAM   = 4'h0;
  localparam logic [MODE_W-1:0] MODE_RAM_ONLY = 4'h1;

  localparam int GRP_CODE_LSB  = 0;
  localparam int GRP_CODE_W    = 3;
  localparam int GRP_REPLY_BIT = 4;
  localparam logic [GRP_CODE_W-1:0] GRP_NONE = 3'h0;
  localparam logic [GRP_CODE_W-1:0] GRP_LAST = 3'h6;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    OP_TBL_POS   = 4'h0,
    OP_TBL_SPD   = 4'h1,
    OP_TBL_ACC   = 4'h2,
    OP_TBL_DEC   = 4'h3,
    OP_TBL_DWELL = 4'h4,
    OP_TBL_AUX   = 4'h5,
    OP_GRP_WR    = 4'h6,
    OP_GRP_RD    = 4'h7,
    OP_ABS_PULSE = 4'h8,
    OP_ABS_CMD   = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } state_t;

endpackage : servo_cmd_pkg

// file: tb/servo_cmd_host_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module servo_cmd_host_assertions (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               reqValid,
  input wire logic               reqReady,
  input wire servo_cmd_pkg::op_t reqOp,
  input wire logic [7:0]         reqEntry,
  input wire logic               reqRamOnly,
  input wire logic               respValid,
  input wire logic [31:0]        respData,
  input wire logic               respErr,
  input wire logic               nvExhausted,
  input wire logic               linkReq,
  input wire logic [7:0]         linkCmd,
  input wire logic [7:0]         linkDataNo,
  input wire logic [3:0]         linkMode,
  input wire logic               linkAck,
  input wire logic [31:0]        linkRdData,
  input wire logic               linkErr
);
  import servo_cmd_pkg::*;

  localparam logic [7:0] TBL [0:5] = '{CMD_TBL_POS, CMD_TBL_SPD, CMD_TBL_ACC,
                                       CMD_TBL_DEC, CMD_TBL_DWELL, CMD_TBL_AUX};
  wire take = reqValid && reqReady;
  wire tblOp = reqOp <= OP_TBL_AUX;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Sequences
  // ****************************************
  sequence refused_s;
    ##1 !linkReq ##1 (respValid && respErr && !linkReq);
  endsequence
  sequence answered_s;
    !linkReq && respValid && respData == $past(linkRdData) && respErr == $past(linkErr);
  endsequence

  // ****************************************
  // Properties
  // ****************************************
  tbl_cmd_a: assert property (
    take && tblOp && reqEntry != 8'h00 |-> ##2
    linkReq && linkCmd == TBL[$past(reqOp, 2)] && linkDataNo == $past(reqEntry, 2))
    else $error("table write sent wrong code or entry");
  entry_zero_a: assert property (
    take && tblOp && reqEntry == 8'h00 |-> refused_s)
    else $error("entry zero not refused");
  ram_mode_a: assert property (
    take && tblOp && reqEntry != 8'h00 && reqRamOnly |-> ##2 linkReq && linkMode == MODE_RAM_ONLY)
    else $error("RAM-only request sent with other mode");
  grp_read_a: assert property (
    take && reqOp == OP_GRP_RD |-> ##2 linkReq && linkCmd == CMD_GRP_RD && linkDataNo == DNO_GROUP)
    else $error("group read sent wrong code");
  abs_read_a: assert property (
    take && reqOp inside {OP_ABS_PULSE, OP_ABS_CMD} |-> ##2 linkReq && linkCmd == CMD_MON_RD &&
    linkDataNo == ($past(reqOp, 2) == OP_ABS_PULSE ? DNO_ABS_PULSE : DNO_ABS_CMD))
    else $error("position read sent wrong code");
  link_hold_a: assert property (
    linkReq && !linkAck |=> !linkReq || $stable(linkCmd) && $stable(linkDataNo) && $stable(linkMode))
    else $error("link fields moved during transfer");
  ack_resp_a: assert property (
    linkReq && linkAck |=> answered_s)
    else $error("reply not passed to user");
  nv_limit_a: assert property (
    $rose(linkReq) && $past(nvExhausted, 2) && linkCmd[7:4] == 4'hC |-> linkMode == MODE_RAM_ONLY)
    else $error("nonvolatile write after limit");
endmodule : servo_cmd_host_assertions

bind servo_cmd_host servo_cmd_host_assertions servo_cmd_host_assertions_inst (.*);

`default_nettype wire

// file: tb/servo_cmd_host_test.sv
`timescale 1ns/10ps
`default_nettype none

module servo_cmd_host_test;
  import servo_cmd_pkg::*;

  localparam int RATE = 50;
  logic        clk, rst_n, reqValid, reqReady, reqRamOnly, reqGroupReply, respValid, respErr;
  logic        respDemoted, nvExhausted, linkReq, linkAck, linkErr, errOn;
  op_t         reqOp;
  logic [2:0]  reqGroup;
  logic [3:0]  linkMode, lastMode;
  logic [7:0]  reqEntry, linkCmd, linkDataNo, ackDelay, lastCmd, lastDno;
  logic [31:0] reqValue, respData, nvWriteCount, linkData, linkRdData, lastData, nvCnt, posPulse, posCmd;
  int          bad_count, total_checks;

  servo_cmd_host #(.NV_RATE_CYC(RATE), .NV_LIMIT(3), .TIMEOUT_CYC(16)) servo_cmd_host_inst (.*);
  station_model station_model_inst (.*);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Group code and reply flag ride in val[2:0] and val[4]
  task automatic send(input op_t op, input logic [7:0] ent, input logic [31:0] val, input logic ram);
    int n;
    @(negedge clk);
    reqOp = op;
    reqEntry = ent;
    reqValue = val;
    reqRamOnly = ram;
    reqGroup = val[2:0];
    reqGroupReply = val[4];
    reqValid = 1'b1;
    for (n = 0; n < 100 && reqReady !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    for (n = 0; n < 100 && respValid !== 1'b1; n++) @(negedge clk);
    check("respValid", 32'h1, 32'(respValid));
  endtask : send

  task automatic test_table();
    logic [7:0] codes [6] = '{CMD_TBL_POS, CMD_TBL_SPD, CMD_TBL_ACC, CMD_TBL_DEC, CMD_TBL_DWELL, CMD_TBL_AUX};
    for (int i = 0; i < 6; i++) begin
      ackDelay = 8'(i);
      send(op_t'(i), i[0] ? 8'hFF : 8'h01, 32'h0000_1000 + 32'(i), 1'b1);
      check("cmd", 32'(codes[i]), 32'(lastCmd));
      check("entry", i[0] ? 32'h0000_00FF : 32'h0000_0001, 32'(lastDno));
      check("data", 32'h0000_1000 + 32'(i), lastData);
      check("mode", 32'(MODE_RAM_ONLY), 32'(lastMode));
      check("err", 32'h0, 32'(respErr));
    end
    $display("table test done");
  endtask : test_table

  task automatic test_refuse();
    send(OP_TBL_POS, 8'h00, 32'h0000_0005, 1'b1);
    check("err", 32'h1, 32'(respErr));
    send(OP_GRP_WR, 8'h00, 32'h0000_0007, 1'b0);
    check("err", 32'h1, 32'(respErr));
    send(op_t'(4'hA), 8'h01, 32'h0000_0000, 1'b0);
    check("err", 32'h1, 32'(respErr));
    check("cmd", 32'(CMD_TBL_AUX), 32'(lastCmd));
    $display("refuse test done");
  endtask : test_refuse

  task automatic test_nv();
    logic [3:0] mode [5] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h1};
    for (int i = 0; i < 5; i++) begin
      if (i > 1) repeat (RATE + 10) @(negedge clk);
      send(OP_TBL_SPD, 8'h10, 32'(i), 1'b0);
      check("mode", 32'(mode[i]), 32'(lastMode));
      check("demoted", 32'(mode[i]), 32'(respDemoted));
    end
    check("nvWriteCount", 32'h3, nvWriteCount);
    check("nvExhausted", 32'h1, 32'(nvExhausted));
    check("nvCnt", 32'h3, nvCnt);
    $display("nv test done");
  endtask : test_nv

  task automatic test_group();
    logic [31:0] w;
    for (int g = 0; g < 7; g++) begin
      w = 32'(g) | (32'(g % 2) << 4);
      send(OP_GRP_WR, 8'h00, w, 1'b0);
      check("cmd", 32'(CMD_GRP_WR), 32'(lastCmd));
      check("group word", w, lastData);
      send(OP_GRP_RD, 8'h00, 32'h0000_0000, 1'b0);
      check("dno", 32'(DNO_GROUP), 32'(lastDno));
      check("group read", w, respData);
    end
    $display("group test done");
  endtask : test_group

  task automatic test_abs();
    posPulse = 32'h0001_86A0;
    posCmd = 32'hFFFF_FFFE;
    send(OP_ABS_PULSE, 8'h00, 32'h0000_0000, 1'b0);
    check("dno", 32'(DNO_ABS_PULSE), 32'(lastDno));
    check("pulse", 32'h0001_86A0, respData);
    send(OP_ABS_CMD, 8'h00, 32'h0000_0000, 1'b0);
    check("dno", 32'(DNO_ABS_CMD), 32'(lastDno));
    check("cmdpos", 32'hFFFF_FFFE, respData);
    $display("abs test done");
  endtask : test_abs

  task automatic test_fault();
    ackDelay = 8'd10;
    errOn = 1'b1;
    send(OP_GRP_RD, 8'h00, 32'h0000_0000, 1'b0);
    check("err", 32'h1, 32'(respErr));
    errOn = 1'b0;
    ackDelay = 8'd40;
    send(OP_GRP_RD, 8'h00, 32'h0000_0000, 1'b0);
    check("timeout err", 32'h1, 32'(respErr));
    check("timeout data", 32'h0, respData);
    ackDelay = 8'd0;
    $display("fault test done");
  endtask : test_fault

  // Mid-run reset must clear the endurance budget and let a fresh write reach both copies
  task automatic test_reset();
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check("reset reqReady", 32'h0, 32'(reqReady));
    check("reset nvWriteCount", 32'h0, nvWriteCount);
    check("reset nvExhausted", 32'h0, 32'(nvExhausted));
    check("reset linkReq", 32'h0, 32'(linkReq));
    repeat (7) @(negedge clk);
    rst_n = 1'b1;
    send(OP_TBL_POS, 8'h01, 32'h0000_0042, 1'b0);
    check("mode", 32'(MODE_NV_RAM), 32'(lastMode));
    check("data", 32'h0000_0042, lastData);
    check("nvWriteCount", 32'h1, nvWriteCount);
    $display("reset test done");
  endtask : test_reset

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {rst_n, reqValid, reqRamOnly, reqGroupReply, errOn, reqGroup} = '0;
    reqOp = OP_TBL_POS;
    {reqEntry, ackDelay, reqValue, posPulse, posCmd} = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    test_table();
    test_refuse();
    test_nv();
    test_group();
    test_abs();
    test_fault();
    test_reset();
    wrap_up();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule : servo_cmd_host_test

`default_nettype wire

// file: tb/station_model.sv
`timescale 1ns/10ps
`default_nettype none

module station_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        linkReq,
  input  wire logic [7:0]  linkCmd,
  input  wire logic [7:0]  linkDataNo,
  input  wire logic [31:0] linkData,
  input  wire logic [3:0]  linkMode,
  input  wire logic [7:0]  ackDelay,
  input  wire logic        errOn,
  input  wire logic [31:0] posPulse,
  input  wire logic [31:0] posCmd,
  output logic             linkAck,
  output logic [31:0]      linkRdData,
  output logic             linkErr,
  output logic [7:0]       lastCmd,
  output logic [7:0]       lastDno,
  output logic [31:0]      lastData,
  output logic [3:0]       lastMode,
  output logic [31:0]      nvCnt
);
  import servo_cmd_pkg::*;

  logic [7:0]  cnt;
  logic [31:0] groupQ;
  wire fire = linkReq && !linkAck && cnt == ackDelay;
  // replies are raw, wrap is the counter's own
  wire [31:0] rdVal = linkCmd == CMD_GRP_RD ? groupQ : linkDataNo == DNO_ABS_PULSE ? posPulse : posCmd;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 8'h00;
      linkAck    <= 1'b0;
      linkErr    <= 1'b0;
      linkRdData <= 32'h0000_0000;
    end else begin
      cnt        <= linkReq && !linkAck ? cnt + 8'h01 : 8'h00;
      linkAck    <= fire;
      linkErr    <= fire && errOn;
      // Idle lines toggle so stale data never passes for a reply
      linkRdData <= fire ? rdVal : ~linkRdData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      groupQ   <= 32'h0000_0000;
      nvCnt    <= 32'h0000_0000;
      lastCmd  <= 8'h00;
      lastDno  <= 8'h00;
      lastData <= 32'h0000_0000;
      lastMode <= 4'h0;
    end else if (fire) begin
      lastCmd  <= linkCmd;
      lastDno  <= linkDataNo;
      lastData <= linkData;
      lastMode <= linkMode;
      if (linkCmd == CMD_GRP_WR) groupQ <= linkData;
      // mode 0 also writes the nonvolatile copy
      if (linkCmd[7:4] == 4'hC && linkMode == MODE_NV_RAM) nvCnt <= nvCnt + 32'h0000_0001;
    end
  end
endmodule : station_model

`default_nettype wire
